// ---- pmcr_pkg.sv ----
// Package of offsets, fields, reset values and codes for the misc configuration register bank.
package pmcr_pkg;
    localparam logic [7:0] OFS_LOAD_PICK = 8'h2E;
    localparam logic [7:0] OFS_LOAD_HIGH = 8'h2F;
    localparam logic [7:0] OFS_LOAD_LOW = 8'h30;
    localparam logic [7:0] OFS_RATE_INFO = 8'h31;
    localparam logic [7:0] OFS_BOOST_LIMIT = 8'h32;
    localparam logic [7:0] OFS_OTP_STATUS = 8'h33;
    localparam logic [7:0] OFS_UNLOCK_KEY = 8'h34;
    localparam logic [7:0] OFS_PIN_DISABLE = 8'h35;
    localparam logic [7:0] KEY_FIRST = 8'h87;
    localparam logic [7:0] KEY_SECOND = 8'h65;
    localparam logic [7:0] KEY_THIRD = 8'h1B;
    localparam int BOOST_RATE_POS = 2;
    localparam int DOUBLE_ERR_POS = 1;
    localparam int SINGLE_ERR_POS = 0;
    localparam int LOCK_FLAG_POS = 1;
    localparam int PERMIT_POS = 0;
    localparam logic [1:0] PICK_RESET = 2'h0;
    localparam logic [8:0] RESULT_RESET = 9'h000;
    localparam logic LOCK_RESET = 1'b1;
    localparam logic PERMIT_RESET = 1'b0;
    localparam logic [7:0] READ_ZERO = 8'h00;
    typedef enum logic [2:0] {
        PMCR_KEY_WAIT1 = 3'b001,
        PMCR_KEY_WAIT2 = 3'b010,
        PMCR_KEY_WAIT3 = 3'b100
    } pmcr_key_e;
endpackage

// ---- pmcr_key_seq.sv ----
// Unlock key sequence tracker and disable-control lock flag.
`timescale 1ns/1ps
`default_nettype none
module pmcr_key_seq (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic key_wr_i,
    input wire logic [7:0] key_byte_i,
    input wire logic watchdog_config_lock_i,
    input wire logic lock_set_i,
    output logic disable_control_lock_flag_o
);
    pmcr_pkg::pmcr_key_e state_reg;
    pmcr_pkg::pmcr_key_e state_next;
    logic lock_next;

    // Next key state: only a matching byte advances, any other byte restarts tracking.
    always_comb begin
        state_next = state_reg;
        lock_next = disable_control_lock_flag_o;
        if (key_wr_i) begin
            state_next = pmcr_pkg::PMCR_KEY_WAIT1;
            lock_next = 1'b1;
            unique case (state_reg)
                pmcr_pkg::PMCR_KEY_WAIT1: begin
                    if (key_byte_i == pmcr_pkg::KEY_FIRST) begin
                        state_next = pmcr_pkg::PMCR_KEY_WAIT2;
                    end
                end
                pmcr_pkg::PMCR_KEY_WAIT2: begin
                    if (key_byte_i == pmcr_pkg::KEY_SECOND) begin
                        state_next = pmcr_pkg::PMCR_KEY_WAIT3;
                    end
                end
                pmcr_pkg::PMCR_KEY_WAIT3: begin
                    // A completed key opens the lock only while the watchdog config is unlocked.
                    if (key_byte_i == pmcr_pkg::KEY_THIRD && !watchdog_config_lock_i) begin
                        lock_next = 1'b0;
                    end
                end
                default: begin
                    state_next = pmcr_pkg::PMCR_KEY_WAIT1;
                end
            endcase
        end
        // Locking the watchdog config always closes the lock, and wins over a key completion.
        if (lock_set_i) begin
            lock_next = 1'b1;
        end
    end

    // Key state register.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= pmcr_pkg::PMCR_KEY_WAIT1;
        end else begin
            state_reg <= state_next;
        end
    end

    // Lock flag register, locked out of reset.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            disable_control_lock_flag_o <= pmcr_pkg::LOCK_RESET;
        end else begin
            disable_control_lock_flag_o <= lock_next;
        end
    end
endmodule
`default_nettype wire

// ---- pmcr_regs.sv ----
// Misc configuration register bank: load measurement, rates, boost limit, OTP status, pin-disable key.
// Behaviour
// - Select codes 0 and 2 pick the first step-down converter, 1 and 3 the second.
// - Every write of the converter-pick register starts a new load measurement.
// - Bit 0 of the high result register shows result bit 8, at 20 mA per step and 10 A full scale.
// - The low result register shows result bits 7 to 0 at the same step.
// - A read-only boost rate bit from OTP selects 2 MHz at 0 and 4 MHz at 1.
// - A read-only two-bit step-down rate field from OTP means 2, 3, 4 and 4 MHz.
// - A writable two-bit boost limit field, defaulted from OTP, selects 1.0, 1.4, 1.9 or 2.8 A.
// - Status bit 1 shows an uncorrectable double error in OTP.
// - Status bit 0 shows a corrected single error in OTP.
// - Writing 0x87, 0x65, 0x1B as three consecutive writes to the key register clears the lock flag.
// - The key sequence is accepted only while the watchdog config lock is zero.
// - Any other key write, or writing the watchdog config lock to one, sets the lock flag again.
// - Reading the key register always returns zero.
// - The lock flag is read-only, resets to one and blocks any change to the pin-disable permit except an OTP load.
// - Apart from an OTP load, the permit may be set only while both the watchdog config lock and the lock flag are zero.
`timescale 1ns/1ps
`default_nettype none
module pmcr_regs (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Internal register port from the serial bus target, one access a cycle.
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Load measurement engine.
    output logic meas_start_o,
    output logic meas_second_o,
    input wire logic meas_done_i,
    input wire logic [8:0] meas_result_i,
    // OTP-loaded defaults and ECC status.
    input wire logic otp_load_i,
    input wire logic otp_boost_rate_i,
    input wire logic [1:0] otp_stepdown_rate_i,
    input wire logic [1:0] otp_boost_limit_i,
    input wire logic otp_permit_i,
    input wire logic otp_double_err_i,
    input wire logic otp_single_err_i,
    // Watchdog link.
    input wire logic watchdog_config_lock_i,
    input wire logic watchdog_lock_wr_one_i,
    output logic boost_rate_bit_o,
    output logic [1:0] stepdown_rate_field_o,
    output logic [1:0] boost_limit_field_o,
    output logic pin_disable_permit_o,
    output logic disable_control_lock_flag_o
);
    logic [1:0] pick_reg;
    logic [8:0] result_reg;
    logic double_err_reg;
    logic single_err_reg;
    logic key_wr;
    logic lock_flag;

    // Returns true when a write hits the given offset.
    function automatic logic wr_hit(input logic wr, input logic [7:0] addr, input logic [7:0] ofs);
        wr_hit = wr && (addr == ofs);
    endfunction

    assign key_wr = wr_hit(reg_wr_i, reg_addr_i, pmcr_pkg::OFS_UNLOCK_KEY);
    assign disable_control_lock_flag_o = lock_flag;

    // Converter pick and measurement start; the start is a one-cycle pulse per write of any value.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pick_reg <= pmcr_pkg::PICK_RESET;
            meas_start_o <= 1'b0;
            meas_second_o <= 1'b0;
        end else begin
            meas_start_o <= wr_hit(reg_wr_i, reg_addr_i, pmcr_pkg::OFS_LOAD_PICK);
            if (wr_hit(reg_wr_i, reg_addr_i, pmcr_pkg::OFS_LOAD_PICK)) begin
                pick_reg <= reg_wdata_i[1:0];
                meas_second_o <= reg_wdata_i[0];
            end
        end
    end

    // Result capture; the whole nine bits update together on each done pulse, so high and low tear only if a pulse falls between their reads.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            result_reg <= pmcr_pkg::RESULT_RESET;
        end else if (meas_done_i) begin
            result_reg <= meas_result_i;
        end
    end

    // OTP-loaded rates and limit; the limit is also host-writable, with host writes after the load.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            boost_rate_bit_o <= 1'b0;
            stepdown_rate_field_o <= 2'h0;
            boost_limit_field_o <= 2'h0;
        end else begin
            if (otp_load_i) begin
                boost_rate_bit_o <= otp_boost_rate_i;
                stepdown_rate_field_o <= otp_stepdown_rate_i;
                boost_limit_field_o <= otp_boost_limit_i;
            end
            if (wr_hit(reg_wr_i, reg_addr_i, pmcr_pkg::OFS_BOOST_LIMIT)) begin
                boost_limit_field_o <= reg_wdata_i[1:0];
            end
        end
    end

    // ECC status follows the OTP controller's report at each load.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            double_err_reg <= 1'b0;
            single_err_reg <= 1'b0;
        end else if (otp_load_i) begin
            double_err_reg <= otp_double_err_i;
            single_err_reg <= otp_single_err_i;
        end
    end

    // Pin-disable permit; clearing needs only the lock flag open, setting needs both locks open.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_disable_permit_o <= pmcr_pkg::PERMIT_RESET;
        end else if (otp_load_i) begin
            pin_disable_permit_o <= otp_permit_i;
        end else if (wr_hit(reg_wr_i, reg_addr_i, pmcr_pkg::OFS_PIN_DISABLE) && !lock_flag) begin
            // A one under the watchdog config lock is refused outright, so it can never clear a set permit.
            if (!reg_wdata_i[pmcr_pkg::PERMIT_POS] || !watchdog_config_lock_i) begin
                pin_disable_permit_o <= reg_wdata_i[pmcr_pkg::PERMIT_POS];
            end
        end
    end

    // Key tracker owns the lock flag.
    pmcr_key_seq u_key (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .key_wr_i(key_wr),
        .key_byte_i(reg_wdata_i),
        .watchdog_config_lock_i(watchdog_config_lock_i),
        .lock_set_i(watchdog_lock_wr_one_i),
        .disable_control_lock_flag_o(lock_flag)
    );

    // Registered read data, one cycle after the read strobe; unmapped offsets read zero.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= pmcr_pkg::READ_ZERO;
        end else if (reg_rd_i) begin
            reg_rdata_o <= pmcr_pkg::READ_ZERO;
            unique case (reg_addr_i)
                pmcr_pkg::OFS_LOAD_PICK: reg_rdata_o[1:0] <= pick_reg;
                pmcr_pkg::OFS_LOAD_HIGH: reg_rdata_o[0] <= result_reg[8];
                pmcr_pkg::OFS_LOAD_LOW: reg_rdata_o <= result_reg[7:0];
                pmcr_pkg::OFS_RATE_INFO: begin
                    reg_rdata_o[pmcr_pkg::BOOST_RATE_POS] <= boost_rate_bit_o;
                    reg_rdata_o[1:0] <= stepdown_rate_field_o;
                end
                pmcr_pkg::OFS_BOOST_LIMIT: reg_rdata_o[1:0] <= boost_limit_field_o;
                pmcr_pkg::OFS_OTP_STATUS: begin
                    reg_rdata_o[pmcr_pkg::DOUBLE_ERR_POS] <= double_err_reg;
                    reg_rdata_o[pmcr_pkg::SINGLE_ERR_POS] <= single_err_reg;
                end
                pmcr_pkg::OFS_UNLOCK_KEY: reg_rdata_o <= pmcr_pkg::READ_ZERO;
                pmcr_pkg::OFS_PIN_DISABLE: begin
                    reg_rdata_o[pmcr_pkg::LOCK_FLAG_POS] <= lock_flag;
                    reg_rdata_o[pmcr_pkg::PERMIT_POS] <= pin_disable_permit_o;
                end
                default: reg_rdata_o <= pmcr_pkg::READ_ZERO;
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- pmcr_checker.sv ----
// Concurrent checks on the ports of the misc configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module pmcr_checker (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic meas_start_o,
    input wire logic meas_second_o,
    input wire logic otp_load_i,
    input wire logic watchdog_config_lock_i,
    input wire logic watchdog_lock_wr_one_i,
    input wire logic [1:0] boost_limit_field_o,
    input wire logic pin_disable_permit_o,
    input wire logic disable_control_lock_flag_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    // A key write starts both key-driven lock checks, so it is named once.
    sequence s_key_wr;
        reg_wr_i && reg_addr_i == pmcr_pkg::OFS_UNLOCK_KEY;
    endsequence
    a_start_pick: assert property (
        reg_wr_i && reg_addr_i == pmcr_pkg::OFS_LOAD_PICK |=> meas_start_o
        && {7'h00, meas_second_o} == ($past(reg_wdata_i) & 8'h01)) else $error("pick write did not start");
    a_key_zero: assert property (
        reg_rd_i && reg_addr_i == pmcr_pkg::OFS_UNLOCK_KEY |=> reg_rdata_o == pmcr_pkg::READ_ZERO)
        else $error("key register read not zero");
    a_relock_key: assert property (
        s_key_wr ##0 reg_wdata_i != pmcr_pkg::KEY_THIRD |=> disable_control_lock_flag_o)
        else $error("lock flag not set by key write");
    a_relock_wd: assert property (watchdog_lock_wr_one_i |=> disable_control_lock_flag_o)
        else $error("lock flag not set by watchdog lock");
    a_lock_held: assert property (s_key_wr ##0 watchdog_config_lock_i |=> disable_control_lock_flag_o)
        else $error("key accepted while watchdog locked");
    a_unlock_cause: assert property (
        $fell(disable_control_lock_flag_o) |-> $past(reg_wr_i) && !$past(watchdog_config_lock_i)
        && $past(reg_addr_i) == pmcr_pkg::OFS_UNLOCK_KEY && $past(reg_wdata_i) == pmcr_pkg::KEY_THIRD)
        else $error("lock flag cleared without third key");
    a_permit_frozen: assert property (
        disable_control_lock_flag_o && !otp_load_i |=> $stable(pin_disable_permit_o))
        else $error("permit changed while locked");
    a_permit_rise: assert property (
        $rose(pin_disable_permit_o) && !$past(otp_load_i) |-> !$past(watchdog_config_lock_i)
        && !$past(disable_control_lock_flag_o)) else $error("permit set while locked");
    a_limit_write: assert property (
        reg_wr_i && reg_addr_i == pmcr_pkg::OFS_BOOST_LIMIT |=> {6'h00, boost_limit_field_o}
        == ($past(reg_wdata_i) & 8'h03)) else $error("boost limit not written");
    a_high_reserved: assert property (
        reg_rd_i && reg_addr_i == pmcr_pkg::OFS_LOAD_HIGH |=> reg_rdata_o[7:1] == 7'h00)
        else $error("high result reserved bits set");
endmodule
bind pmcr_regs pmcr_checker pmcr_checker_i (.*);
`default_nettype wire

// ---- pmcr_meas_model.sv ----
// Behavioural load-measurement engine that answers each start after a delay.
`timescale 1ns/1ps
`default_nettype none
module pmcr_meas_model #(parameter int DELAY = 5) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic meas_start_i,
    input wire logic meas_second_i,
    input wire logic [8:0] result_first_i,
    input wire logic [8:0] result_second_i,
    output logic meas_done_o,
    output logic [8:0] meas_result_o
);
    int cnt;
    // A new start restarts the count; outside the done pulse the result toggles so a late capture shows.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt <= 0;
            meas_done_o <= 1'b0;
            meas_result_o <= 9'h1FF;
        end else begin
            meas_done_o <= (cnt == 1);
            meas_result_o <= (cnt == 1) ? (meas_second_i ? result_second_i : result_first_i) : ~meas_result_o;
            cnt <= meas_start_i ? DELAY : (cnt > 0 ? cnt - 1 : 0);
        end
    end
endmodule
`default_nettype wire

// ---- pmcr_regs_tb.sv ----
// Self-checking testbench of the misc configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module pmcr_regs_tb;
    logic clk_sys_i = 0, sys_rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, otp_load_i = 0, otp_boost_rate_i = 0;
    logic otp_permit_i = 0, otp_double_err_i = 0, otp_single_err_i = 0;
    logic watchdog_config_lock_i = 0, watchdog_lock_wr_one_i = 0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
    logic [1:0] otp_stepdown_rate_i = 2'h0, otp_boost_limit_i = 2'h0, stepdown_rate_field_o, boost_limit_field_o;
    logic meas_start_o, meas_second_o, meas_done_i, boost_rate_bit_o, pin_disable_permit_o;
    logic disable_control_lock_flag_o;
    logic [8:0] meas_result_i;
    int num_errors = 0, num_checks = 0;
    localparam logic [8:0] RES_A = 9'h1F4, RES_B = 9'h0A5;
    pmcr_regs pmcr_regs_i (.*);
    pmcr_meas_model pmcr_meas_model_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .meas_start_i(meas_start_o),
        .meas_second_i(meas_second_o), .result_first_i(RES_A), .result_second_i(RES_B),
        .meas_done_o(meas_done_i), .meas_result_o(meas_result_i));
    // Free-running 100 MHz clock.
    initial forever #5 clk_sys_i = ~clk_sys_i;
    task automatic report_and_stop();
        if (num_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask
    // Each access holds its strobe for exactly one sampling edge, then waits for the result to land.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1;
        chk(reg_rdata_o, e);
    endtask
    task automatic keys(input logic [23:0] k);
        for (int i = 2; i >= 0; i--) wr(pmcr_pkg::OFS_UNLOCK_KEY, k[i*8 +: 8]);
    endtask
    task automatic otp(input logic [7:0] v);
        @(posedge clk_sys_i);
        otp_load_i <= 1'b1;
        {otp_boost_rate_i, otp_stepdown_rate_i, otp_boost_limit_i, otp_permit_i, otp_double_err_i,
            otp_single_err_i} <= v;
        @(posedge clk_sys_i);
        otp_load_i <= 1'b0;
        #1;
    endtask
    task automatic t_reset_vals();
        for (int a = 8'h2E; a <= 8'h34; a++) rd(8'(a), 8'h00);
        rd(pmcr_pkg::OFS_PIN_DISABLE, 8'h02);
    endtask
    task automatic t_otp();
        otp(8'b1_11_10_1_1_0);
        chk({5'h00, boost_rate_bit_o, stepdown_rate_field_o}, 8'h07);
        chk({6'h00, boost_limit_field_o}, 8'h02);
        chk({7'h00, pin_disable_permit_o}, 8'h01);
        rd(pmcr_pkg::OFS_PIN_DISABLE, 8'h03);
        rd(pmcr_pkg::OFS_RATE_INFO, 8'h07);
        wr(pmcr_pkg::OFS_RATE_INFO, 8'hF8);
        rd(pmcr_pkg::OFS_RATE_INFO, 8'h07);
        rd(pmcr_pkg::OFS_BOOST_LIMIT, 8'h02);
        rd(pmcr_pkg::OFS_OTP_STATUS, 8'h02);
        otp(8'b0_10_00_0_0_1);
        chk({5'h00, boost_rate_bit_o, stepdown_rate_field_o}, 8'h02);
        rd(pmcr_pkg::OFS_RATE_INFO, 8'h02);
        rd(pmcr_pkg::OFS_OTP_STATUS, 8'h01);
    endtask
    task automatic t_limit();
        for (int v = 3; v >= 0; v--) begin
            wr(pmcr_pkg::OFS_BOOST_LIMIT, 8'(v));
            chk({6'h00, boost_limit_field_o}, 8'(v));
            rd(pmcr_pkg::OFS_BOOST_LIMIT, 8'(v));
        end
    endtask
    task automatic t_meas();
        logic [8:0] e;
        int n;
        for (int p = 0; p < 4; p++) begin
            e = p[0] ? RES_B : RES_A;
            wr(pmcr_pkg::OFS_LOAD_PICK, 8'(p));
            chk({6'h00, meas_second_o, meas_start_o}, {6'h00, p[0], 1'b1});
            for (n = 0; n < 20 && meas_done_i !== 1'b1; n++) @(posedge clk_sys_i);
            chk(8'(n < 20), 8'h01);
            rd(pmcr_pkg::OFS_LOAD_HIGH, {7'h00, e[8]});
            rd(pmcr_pkg::OFS_LOAD_LOW, e[7:0]);
        end
    endtask
    task automatic t_unlock();
        @(posedge clk_sys_i);
        watchdog_config_lock_i <= 1'b1;
        keys(24'h87651B);
        chk({7'h00, disable_control_lock_flag_o}, 8'h01);
        @(posedge clk_sys_i);
        watchdog_config_lock_i <= 1'b0;
        wr(pmcr_pkg::OFS_UNLOCK_KEY, pmcr_pkg::KEY_FIRST);
        wr(pmcr_pkg::OFS_BOOST_LIMIT, 8'h01);
        wr(pmcr_pkg::OFS_UNLOCK_KEY, pmcr_pkg::KEY_SECOND);
        wr(pmcr_pkg::OFS_UNLOCK_KEY, pmcr_pkg::KEY_THIRD);
        chk({7'h00, disable_control_lock_flag_o}, 8'h00);
        rd(pmcr_pkg::OFS_UNLOCK_KEY, 8'h00);
        wr(pmcr_pkg::OFS_PIN_DISABLE, 8'h01);
        chk({7'h00, pin_disable_permit_o}, 8'h01);
        @(posedge clk_sys_i);
        watchdog_config_lock_i <= 1'b1;
        wr(pmcr_pkg::OFS_PIN_DISABLE, 8'h01);
        chk({7'h00, pin_disable_permit_o}, 8'h01);
        wr(pmcr_pkg::OFS_PIN_DISABLE, 8'h00);
        chk({7'h00, pin_disable_permit_o}, 8'h00);
        wr(pmcr_pkg::OFS_PIN_DISABLE, 8'h01);
        chk({7'h00, pin_disable_permit_o}, 8'h00);
        @(posedge clk_sys_i);
        watchdog_config_lock_i <= 1'b0;
        wr(pmcr_pkg::OFS_PIN_DISABLE, 8'h01);
        chk({7'h00, pin_disable_permit_o}, 8'h01);
        wr(pmcr_pkg::OFS_UNLOCK_KEY, 8'h00);
        wr(pmcr_pkg::OFS_PIN_DISABLE, 8'h00);
        rd(pmcr_pkg::OFS_PIN_DISABLE, 8'h03);
        keys(24'h878765);
        wr(pmcr_pkg::OFS_UNLOCK_KEY, pmcr_pkg::KEY_THIRD);
        chk({7'h00, disable_control_lock_flag_o}, 8'h01);
        keys(24'h87651B);
        chk({7'h00, disable_control_lock_flag_o}, 8'h00);
        @(posedge clk_sys_i);
        watchdog_lock_wr_one_i <= 1'b1;
        @(posedge clk_sys_i);
        watchdog_lock_wr_one_i <= 1'b0;
        #1;
        chk({7'h00, disable_control_lock_flag_o}, 8'h01);
    endtask
    // A mid-run reset must bring back the locked flag and clear the permit and limit.
    task automatic t_reset_again();
        @(posedge clk_sys_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        rd(pmcr_pkg::OFS_PIN_DISABLE, 8'h02);
        rd(pmcr_pkg::OFS_BOOST_LIMIT, 8'h00);
    endtask
    // Reset for eight cycles, then run every scenario in turn.
    initial begin
        repeat (8) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        t_reset_vals();
        t_otp();
        t_limit();
        t_meas();
        t_unlock();
        t_reset_again();
        report_and_stop();
    end
    // The scenarios need under two hundred cycles, so this limit only trips on a hang.
    initial begin
        #100000;
        num_errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire
